// ---- common/sms_pkg.sv ----
package sms_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [3:0] SMS_ADDR_DATA   = 4'h0;
  localparam logic [3:0] SMS_ADDR_CTRL   = 4'h1;
  localparam logic [3:0] SMS_ADDR_STATUS = 4'h2;
  localparam logic [3:0] SMS_ADDR_MASK   = 4'h3;

  localparam logic [7:0] SMS_DATA_RESET   = 8'h00;
  localparam logic [7:0] SMS_CTRL_RESET   = 8'h00;
  localparam logic [7:0] SMS_STATUS_RESET = 8'h00;
  localparam logic [7:0] SMS_MASK_RESET   = 8'h00;

  // field positions of the control and status registers
  localparam int SMS_CTRL_EN_BIT   = 7;
  localparam int SMS_CTRL_BUSY_BIT = 4;
  localparam int SMS_CTRL_POL_BIT   = 3;
  localparam int SMS_CTRL_PHASE_BIT = 2;
  localparam int SMS_STATUS_DONE_BIT = 0;

  // ----------------------------------------------------------------
  // shift clock rates
  // ----------------------------------------------------------------
  localparam int SMS_CORE_REF_HZ = 12_000_000;
  localparam int SMS_MAX_SCK_HZ  = 1_500_000;
  localparam logic [8:0] SMS_DIV_00 = 9'(SMS_CORE_REF_HZ / SMS_MAX_SCK_HZ);
  localparam logic [8:0] SMS_DIV_01 = 9'h010;
  localparam logic [8:0] SMS_DIV_10 = 9'h080;
  localparam logic [8:0] SMS_DIV_11 = 9'h100;

  localparam int         SMS_BITS      = 8;
  localparam logic [3:0] SMS_LAST_EDGE = 4'(2 * SMS_BITS - 1);

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       port_enable_bit;
    logic [1:0] spare;
    logic       busy_flag;
    logic       clock_idle_polarity;
    logic       clock_phase_select;
    logic       rate_select_high;
    logic       rate_select_low;
  } sms_ctrl_t;

  typedef struct packed {
    logic sclk_o;
    logic sclk_oe;
    logic serial_out_line_o;
    logic serial_out_line_oe;
  } sms_pins_t;

  typedef enum logic [1:0] {
    SMS_IDLE  = 2'b01,
    SMS_SHIFT = 2'b10
  } sms_state_t;

endpackage

// ---- src/sms_spi_master_shifter.sv ----
// How it works
// (R1) a data write loads the byte and shifts it out msb first
// (R2) full duplex on three lines, slave data sampled on the same clock
// (R3) received bits replace sent bits; no separate tx or rx flags
// (R4) at byte end the shift register is copied into the read buffer
// (R5) master only: shift clock is made here by dividing the core clock
// (R6) fastest rate is one eighth of the core clock
// (R7) four rates picked by a two bit field
// (R8) software sets clock idle polarity and clock phase
// (R9) an interrupt is raised after each completed byte
// (R10) rate field divides by 8, 16, 128, 256
// (R11) busy flag is high during a transfer, low after it
// (R12) with the port disabled clock and data outputs float
// (R13) writing the data register alone starts a transfer
// (R14) phase clear: capture first edge; phase set: change first edge
// (R15) eight clock cycles per byte, clock idles at its polarity level
//
// The placing of the registers and strobed register access are this design's own decisions.
`timescale 1ns/1ps

module sms_spi_master_shifter
  import sms_pkg::*;
#(
  parameter int ADDR_W = 4
) (
  input  wire logic              clock,
  input  wire logic              sys_rst,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [7:0]        wr_data,
  input  wire logic              wr_en,
  input  wire logic              rd_en,
  output logic      [7:0]        rd_data,
  output logic                   irq,
  input  wire logic              serial_in_line,
  output sms_pins_t              pins
);

  if (ADDR_W < 2) begin : g_addr_w_check
    $error("ADDR_W must be at least 2");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  sms_ctrl_t   ctrl_reg;
  sms_state_t  state_reg;
  logic [7:0]  shift_reg;
  logic [7:0]  read_buf_reg;
  logic [7:0]  status_reg;
  logic [7:0]  mask_reg;
  logic [7:0]  rd_data_reg;
  logic [7:0]  div_cnt_reg;
  logic [3:0]  edge_cnt_reg;
  logic        phase_reg;
  logic        sample_reg;
  logic        serial_in_s1_reg;
  logic        serial_in_s2_reg;
  logic        out_bit_reg;

  logic        busy;
  logic        enabled;
  logic        phase_sel;
  logic [1:0]  rate_sel;
  logic [7:0]  reload;
  logic        tick;
  logic        cap_edge;
  logic        last_edge;
  logic        done;
  logic        start;
  logic [7:0]  shift_next;
  logic        sel_data;
  logic        sel_ctrl;
  logic        sel_status;
  logic        sel_mask;

  assign sel_data   = (addr == ADDR_W'(SMS_ADDR_DATA));
  assign sel_ctrl   = (addr == ADDR_W'(SMS_ADDR_CTRL));
  assign sel_status = (addr == ADDR_W'(SMS_ADDR_STATUS));
  assign sel_mask   = (addr == ADDR_W'(SMS_ADDR_MASK));

  assign busy     = (state_reg == SMS_SHIFT);                    // see R11
  assign enabled  = ctrl_reg.port_enable_bit;
  assign phase_sel = ctrl_reg.clock_phase_select;
  assign rate_sel = {ctrl_reg.rate_select_high, ctrl_reg.rate_select_low};

  // a write while busy is dropped so a running byte is never torn
  assign start = wr_en && sel_data && enabled && !busy;          // see R13

  // ----------------------------------------------------------------
  // serial input synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      serial_in_s1_reg <= 1'b0;
      serial_in_s2_reg <= 1'b0;
    end else begin
      serial_in_s1_reg <= serial_in_line;                        // see R2
      serial_in_s2_reg <= serial_in_s1_reg;
    end
  end

  // ----------------------------------------------------------------
  // rate divider
  // ----------------------------------------------------------------
  always_comb begin
    case (rate_sel)                                              // see R7
      2'b00:   reload = 8'((SMS_DIV_00 >> 1) - 9'h001);          // see R6
      2'b01:   reload = 8'((SMS_DIV_01 >> 1) - 9'h001);          // see R10
      2'b10:   reload = 8'((SMS_DIV_10 >> 1) - 9'h001);
      2'b11:   reload = 8'((SMS_DIV_11 >> 1) - 9'h001);
      default: reload = 8'((SMS_DIV_00 >> 1) - 9'h001);
    endcase
  end

  // each tick is one shift clock edge, half a shift period apart
  assign tick = busy && (div_cnt_reg == 8'h00);                  // see R5

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      div_cnt_reg <= 8'h00;
    end else if (start || tick) begin
      div_cnt_reg <= reload;
    end else if (busy) begin
      div_cnt_reg <= div_cnt_reg - 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // edge sequencing
  // ----------------------------------------------------------------
  assign cap_edge  = (edge_cnt_reg[0] == phase_sel);             // see R14
  assign last_edge = (edge_cnt_reg == SMS_LAST_EDGE);
  assign done      = tick && last_edge;

  always_comb begin
    if (cap_edge) begin
      shift_next = {shift_reg[6:0], serial_in_s2_reg};
    end else begin
      shift_next = {shift_reg[6:0], sample_reg};
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_reg <= SMS_IDLE;
    end else begin
      case (state_reg)
        SMS_IDLE: begin
          if (start) begin
            state_reg <= SMS_SHIFT;
          end
        end
        SMS_SHIFT: begin
          if (!enabled || done) begin                            // see R11
            state_reg <= SMS_IDLE;
          end
        end
        default: state_reg <= SMS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      edge_cnt_reg <= 4'h0;
      phase_reg    <= 1'b0;
    end else if (start || !enabled) begin
      edge_cnt_reg <= 4'h0;
      phase_reg    <= 1'b0;
    end else if (tick) begin
      edge_cnt_reg <= edge_cnt_reg + 4'h1;
      phase_reg    <= ~phase_reg;                                // see R15
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sample_reg <= 1'b0;
    end else if (tick && cap_edge) begin
      sample_reg <= serial_in_s2_reg;                            // see R2
    end
  end

  // the change edge that opens a phase-set byte has nothing to shift yet;
  // with phase set the final capture also performs the last shift
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      shift_reg <= SMS_DATA_RESET;
    end else if (start) begin
      shift_reg <= wr_data;                                      // see R1
    end else if (tick) begin
      if ((!cap_edge && !(phase_sel && edge_cnt_reg == 4'h0)) || (cap_edge && last_edge)) begin
        shift_reg <= shift_next;                                 // see R3
      end
    end
  end

  // the pin has its own flip-flop so data never moves on a capture edge,
  // not even when the last phase-set capture shifts the register
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      out_bit_reg <= 1'b0;
    end else if (start) begin
      out_bit_reg <= wr_data[7];                                 // see R1
    end else if (tick && !cap_edge && !(phase_sel && edge_cnt_reg == 4'h0)) begin
      out_bit_reg <= shift_next[7];                              // see R14
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      read_buf_reg <= SMS_DATA_RESET;
    end else if (done) begin
      read_buf_reg <= shift_next;                                // see R4
    end
  end

  // ----------------------------------------------------------------
  // pins
  // ----------------------------------------------------------------
  always_comb begin
    pins.sclk_o             = ctrl_reg.clock_idle_polarity ^ phase_reg;   // see R8
    pins.sclk_oe            = enabled;                                    // see R12
    pins.serial_out_line_o  = out_bit_reg;                                // see R1
    pins.serial_out_line_oe = enabled;
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ctrl_reg <= SMS_CTRL_RESET;
    end else if (wr_en && sel_ctrl) begin
      ctrl_reg           <= wr_data;
      ctrl_reg.busy_flag <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      mask_reg <= SMS_MASK_RESET;
    end else if (wr_en && sel_mask) begin
      mask_reg <= wr_data;
    end
  end

  // a completion in the same cycle as the clearing read survives
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      status_reg <= SMS_STATUS_RESET;
    end else if (done) begin
      status_reg[SMS_STATUS_DONE_BIT] <= 1'b1;                   // see R9
    end else if (rd_en && sel_status) begin
      status_reg <= SMS_STATUS_RESET;
    end
  end

  assign irq = |(status_reg & mask_reg);                         // see R9

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rd_data_reg <= 8'h00;
    end else if (rd_en) begin
      if (sel_data) begin
        rd_data_reg <= read_buf_reg;                             // see R4
      end else if (sel_ctrl) begin
        rd_data_reg <= {ctrl_reg[7:5], busy, ctrl_reg[3:0]};     // see R11
      end else if (sel_status) begin
        rd_data_reg <= status_reg;
      end else if (sel_mask) begin
        rd_data_reg <= mask_reg;
      end else begin
        rd_data_reg <= 8'h00;
      end
    end else begin
      rd_data_reg <= 8'h00;
    end
  end

  assign rd_data = rd_data_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  logic [4:0] toggle_cnt_reg;

  always_ff @(posedge clock) begin
    if (sys_rst || start) begin
      toggle_cnt_reg <= 5'h00;
    end else if (tick) begin
      toggle_cnt_reg <= toggle_cnt_reg + 5'h01;
    end
  end

  a_msb_first_out: assert property (start |=> pins.serial_out_line_o == $past(wr_data[7])) // see R1
    else $error("msb not on serial output after load");

  a_write_starts_busy: assert property (start |=> busy ##0 ctrl_reg == $past(ctrl_reg) || !busy) // see R13
    else $error("data write did not start a transfer");

  a_busy_clears_done: assert property (done |=> !busy && status_reg[SMS_STATUS_DONE_BIT]) // see R11
    else $error("busy not cleared or done not flagged at byte end");

  a_read_buffer_load: assert property (done |=> read_buf_reg == $past(shift_next)) // see R4
    else $error("read buffer not loaded at byte end");

  a_eight_clocks: assert property (done |-> toggle_cnt_reg == 5'h0f) // see R15
    else $error("byte did not take sixteen clock edges");

  a_idle_level: assert property (enabled && !busy |-> pins.sclk_o == ctrl_reg.clock_idle_polarity) // see R15
    else $error("shift clock not at idle level");

  a_float_when_off: assert property (!enabled |-> !pins.sclk_oe && !pins.serial_out_line_oe) // see R12
    else $error("outputs driven while disabled");

  a_drive_own_clock: assert property (tick && enabled && !(wr_en && sel_ctrl) // see R5
    |=> pins.sclk_oe && pins.sclk_o != $past(pins.sclk_o))
    else $error("shift clock not toggled after a divider tick");

  a_fast_rate: assert property (tick && !last_edge && rate_sel == 2'b00 && enabled && !(wr_en && sel_ctrl) // see R6
    |=> !tick [*3] ##1 tick)
    else $error("fastest rate not one eighth of core clock");

  a_rate_sixteen: assert property (tick && !last_edge && rate_sel == 2'b01 && enabled && !(wr_en && sel_ctrl) // see R10
    |=> !tick [*7] ##1 tick)
    else $error("rate 01 half period wrong");

  a_capture_edge: assert property (tick && cap_edge |=> sample_reg == $past(serial_in_s2_reg)) // see R14
    else $error("input not captured on capture edge");

  a_data_steady_capture: assert property (tick && cap_edge |=> $stable(pins.serial_out_line_o)) // see R14
    else $error("serial output moved on a capture edge");

  a_irq_after_byte: assert property (done && mask_reg[SMS_STATUS_DONE_BIT] |=> irq) // see R9
    else $error("no interrupt after completed byte");

endmodule

// ---- sim/sms_slave_model.sv ----
`timescale 1ns/1ps
// ------------------------------------------------------------
// serial slave behind the three-line port
// ------------------------------------------------------------
module sms_slave_model (
  input  wire logic       clock,
  input  wire logic       sclk,
  input  wire logic       mosi,
  input  wire logic       idle_pol,
  input  wire logic       phase_sel,
  input  wire logic       load,
  input  wire logic [7:0] tx,
  output logic            miso,
  output logic [7:0]      rx
);
  logic [7:0] sh = '0;
  logic       active = 0;
  logic       first = 0;
  logic       tgl = 0;
  int         caps = 0;
  // outside a frame the line keeps changing so a stale bit never passes
  assign miso = active ? sh[7] : tgl;
  always @(posedge clock) begin
    tgl <= ~tgl;
    if (load) begin
      sh <= tx;
      active <= 1'b1;
      first <= 1'b1;
      caps <= 0;
    end
  end
  // reacts on the wire itself: sampling on the core clock would lose a cycle
  always @(sclk) begin
    if (active) begin
      if ((sclk != idle_pol) ^ phase_sel) begin
        rx <= {rx[6:0], mosi};
        caps <= caps + 1;
        if (caps == 7) active <= 1'b0;
      end else if (!(first && phase_sel)) sh <= {sh[6:0], 1'b0};
      first <= 1'b0;
    end
  end
endmodule

// ---- sim/tb.sv ----
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin fails++; $display("Error t=%0t got %h exp %h", $time, (a), (b)); end end
module tb;
  import sms_pkg::*;
  logic        clock = 0, sys_rst = 1, wr_en = 0, rd_en = 0, load = 0, tgl = 0, msk = 0, sclk_q = 0;
  logic [3:0]  addr = '0;
  logic [7:0]  wr_data = '0, s_tx = '0, rd_data, rx, d;
  logic        irq, miso, sclk_w, serial_out_w;
  logic [31:0] seed = 32'h0000_0041;
  sms_pins_t   pins;
  sms_ctrl_t   ctl = '0;
  int          fails = 0, n_compared = 0, cyc = 0, tog = 0, t_first = 0, t_last = 0;
  // ------------------------------------------------------------
  // design, slave and wire resolution
  // ------------------------------------------------------------
  // the clock line has a resistor to the idle level; data has none
  assign sclk_w = pins.sclk_oe ? pins.sclk_o : ctl.clock_idle_polarity;
  assign serial_out_w = pins.serial_out_line_oe ? pins.serial_out_line_o : tgl;
  sms_spi_master_shifter sms_spi_master_shifter_inst (.clock(clock), .sys_rst(sys_rst), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .irq(irq),
    .serial_in_line(miso), .pins(pins));
  sms_slave_model sms_slave_model_inst (.clock(clock), .sclk(sclk_w), .mosi(serial_out_w),
    .idle_pol(ctl.clock_idle_polarity), .phase_sel(ctl.clock_phase_select), .load(load), .tx(s_tx),
    .miso(miso), .rx(rx));
  initial begin
    forever #2 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc <= cyc + 1;
    tgl <= ~tgl;
    sclk_q <= pins.sclk_o;
    if (pins.sclk_oe && pins.sclk_o !== sclk_q) begin
      tog = tog + 1;
      if (tog == 1) t_first = cyc;
      t_last = cyc;
    end
    if (cyc > 40000) begin
      fails++;
      report_and_stop();
    end
  end
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic int half_div(input logic [1:0] r);
    return (r == 2'b00) ? 4 : (r == 2'b01) ? 8 : (r == 2'b10) ? 64 : 128;
  endfunction
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clock);
    addr <= a;
    wr_data <= v;
    wr_en <= 1'b1;
    @(posedge clock);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clock);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clock);
    rd_en <= 1'b0;
    #1 v = rd_data;
  endtask
  task automatic start(input logic [7:0] cv, input logic [7:0] mt, input logic [7:0] st);
    ctl = cv;
    wr(SMS_ADDR_CTRL, cv);
    @(posedge clock);
    load <= 1'b1;
    s_tx <= st;
    @(posedge clock);
    load <= 1'b0;
    tog = 0;
    wr(SMS_ADDR_DATA, mt);
  endtask
  task automatic xfer(input logic [7:0] cv, input bit extra);
    logic [7:0] mt, st;
    int k;
    mt = 8'(rnd());
    st = 8'(rnd());
    start(cv, mt, st);
    rd(SMS_ADDR_CTRL, d);
    `CHK(d[SMS_CTRL_BUSY_BIT], 1'b1)
    if (extra) wr(SMS_ADDR_DATA, ~mt);
    k = 0;
    do begin
      rd(SMS_ADDR_CTRL, d);
      k++;
    end while (d[SMS_CTRL_BUSY_BIT] !== 1'b0 && k < 2000);
    `CHK(d[SMS_CTRL_BUSY_BIT], 1'b0)
    `CHK(pins.sclk_oe, 1'b1)
    `CHK(tog, 16)
    `CHK(t_last - t_first, 15 * half_div(cv[1:0]))
    `CHK(sclk_w, cv[3])
    `CHK(rx, mt)
    rd(SMS_ADDR_DATA, d);
    `CHK(d, st)
    `CHK(irq, msk)
    rd(SMS_ADDR_STATUS, d);
    `CHK(d, 8'h01)
    `CHK(irq, 1'b0)
    $display("transfer ctrl %h done", cv);
  endtask
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clock);
    sys_rst <= 1'b0;
    for (int a = 0; a < 5; a++) begin
      rd(4'(a), d);
      `CHK(d, 8'h00)
    end
    `CHK(pins, 4'h0)
    $display("reset test done");
    wr(SMS_ADDR_MASK, 8'h01);
    msk = 1'b1;
    for (int m = 0; m < 16; m++) xfer({4'h8, 4'(m)}, m == 5);
    wr(SMS_ADDR_MASK, 8'h00);
    msk = 1'b0;
    xfer(8'h81, 1'b0);
    start(8'h83, 8'(rnd()), 8'h5a);
    repeat (300) @(posedge clock);
    ctl = 8'h03;
    wr(SMS_ADDR_CTRL, 8'h03);
    wr(SMS_ADDR_DATA, 8'ha5);
    rd(SMS_ADDR_CTRL, d);
    `CHK(d, 8'h03)
    `CHK({pins.sclk_oe, pins.serial_out_line_oe}, 2'b00)
    rd(SMS_ADDR_STATUS, d);
    `CHK(d, 8'h00)
    $display("abort test done");
    report_and_stop();
  end
endmodule
